//--- rtl/pwr_oc_pkg.sv
// constants, register map and state types for port power / overcurrent control
// assumes one 40 MHz core clock and an APB master with 32-bit data
package pwr_oc_pkg;
    localparam int NUM_PORTS = 6;
    localparam int NUM_FILT = 7;
    localparam int SHARED_IDX = 6;
    localparam int ADDR_W = 18;

    // timing: 1 ms tick from the core clock
    localparam int CLK_MHZ = 40;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_CYCLES = TICK_PERIOD_US * CLK_MHZ;
    localparam int TICK_W = 16;

    // register indices, byte address is four times the index
    localparam logic [15:0] IDX_MIN_WIDTH = 16'h30EA;
    localparam logic [15:0] IDX_INACTIVE = 16'h30EB;
    localparam logic [15:0] IDX_LOCKOUT = 16'h30E1;
    localparam logic [15:0] IDX_PWR_CTRL = 16'h30F0;
    localparam logic [15:0] IDX_CONFIG = 16'h30F1;
    localparam logic [15:0] IDX_STATUS = 16'h30F2;
    localparam logic [15:0] IDX_MASK = 16'h30F3;
    localparam logic [15:0] IDX_PIN_STATE = 16'h30F4;

    // field layout
    localparam int WIDTH_W = 4;
    localparam int WIN_W = 8;
    localparam int CFG_GANG_BIT = 0;
    localparam int CFG_BC_LSB = 8;

    // reset values
    localparam logic [3:0] MIN_WIDTH_RST = 4'h5;
    localparam logic [7:0] INACTIVE_RST = 8'h14;
    localparam logic [7:0] LOCKOUT_RST = 8'h0A;

    typedef enum logic [3:0] {
        SEL_NONE, SEL_MIN_WIDTH, SEL_INACTIVE, SEL_LOCKOUT, SEL_PWR_CTRL,
        SEL_CONFIG, SEL_STATUS, SEL_MASK, SEL_PIN_STATE
    } reg_sel_t;

    typedef struct packed {
        logic prev_en;
        logic prev_low;
        logic [WIN_W-1:0] lock;
        logic [WIDTH_W-1:0] low_cnt;
        logic [WIN_W-1:0] win;
        logic oc;
    } filt_state_t;

    typedef struct packed {
        logic [NUM_FILT-1:0] sync1;
        logic [NUM_FILT-1:0] sync2;
        logic [TICK_W-1:0] tick_cnt;
        logic tick;
        logic [NUM_PORTS-1:0] pwr;
        logic gang;
        logic [NUM_PORTS-1:0] bc;
        logic [WIDTH_W-1:0] min_width;
        logic [WIN_W-1:0] inactive;
        logic [WIN_W-1:0] lockout;
        logic [NUM_PORTS-1:0] status;
        logic [NUM_PORTS-1:0] mask;
        logic [NUM_PORTS-1:0] pin_oe_n;
        logic sh_oe_n;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } top_state_t;
endpackage : pwr_oc_pkg

//--- rtl/oc_filter_if.sv
// bundle between the controller and one overcurrent sense filter
// assumes all signals on the core clock
`timescale 1ns/1ps
interface oc_filter_if;
    import pwr_oc_pkg::*;
    logic en;
    logic low;
    logic tick;
    logic [WIDTH_W-1:0] width;
    logic [WIN_W-1:0] window;
    logic [WIN_W-1:0] lockout;
    logic oc;
    modport filter (input en, low, tick, width, window, lockout, output oc);
    modport ctl (output en, low, tick, width, window, lockout, input oc);
endinterface : oc_filter_if

//--- rtl/oc_filter.sv
// overcurrent sense filter for one pin: lockout, single and double pulse
// assumes a synchronised low level and a one-cycle 1 ms tick
`timescale 1ns/1ps
module oc_filter (
    input wire logic clk,
    input wire logic rst_n,
    oc_filter_if.filter fif
);
    import pwr_oc_pkg::*;

    filt_state_t s;
    filt_state_t next_s;
    logic grp_start;

    assign grp_start = fif.low && !s.prev_low;
    assign fif.oc = s.oc;

    always_comb begin
        next_s = s;
        next_s.oc = 1'b0;
        next_s.prev_en = fif.en;
        next_s.prev_low = fif.low;
        if (!fif.en) begin // see R9
            next_s.lock = '0;
            next_s.low_cnt = '0;
            next_s.win = '0;
        end else if (!s.prev_en) begin
            next_s.lock = fif.lockout; // see R16
            next_s.low_cnt = '0;
            next_s.win = '0;
        end else if (s.lock != '0) begin
            // ramp-up lows are simply ignored here
            if (fif.tick) begin
                next_s.lock = s.lock - 8'h01; // see R16
            end
            next_s.low_cnt = '0;
            next_s.win = '0;
        end else begin
            if (!fif.low) begin
                next_s.low_cnt = '0; // see R12
            end else if (fif.tick && s.low_cnt != 4'hF) begin
                next_s.low_cnt = s.low_cnt + 4'h1;
            end
            if (fif.tick && s.win != '0) begin
                next_s.win = s.win - 8'h01; // see R15
            end
            if (fif.low && fif.width == '0) begin
                next_s.oc = 1'b1; // see R14
            end
            if (fif.tick && fif.low && (5'(s.low_cnt) + 5'h01 >= 5'(fif.width))) begin
                next_s.oc = 1'b1; // see R10
            end
            if (grp_start) begin
                if (s.win != '0) begin
                    next_s.oc = 1'b1; // see R11
                end else begin
                    next_s.win = fif.window; // see R11
                end
            end
            if (next_s.oc) begin
                next_s.low_cnt = '0;
                next_s.win = '0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_lockout_quiet: assert property (s.prev_en && fif.en && s.lock != '0 |=> !s.oc) // see R16
        else $error("overcurrent flagged during lockout");
    a_single_trip: assert property (fif.en && s.prev_en && s.lock == '0 && fif.tick && fif.low
        && fif.width != '0 && s.low_cnt + 4'h1 == fif.width |=> s.oc) // see R10
        else $error("long low pulse not flagged");
    a_double_trip: assert property (fif.en && s.prev_en && s.lock == '0 && grp_start
        && s.win != '0 |=> s.oc) // see R11
        else $error("second low group in window not flagged");
    a_disabled_quiet: assert property (!fif.en |=> !s.oc) // see R9
        else $error("overcurrent flagged on disabled pin");
    a_lock_load: assert property ($rose(fif.en) |=> s.lock == $past(fif.lockout)) // see R16
        else $error("lockout not loaded at power on");
endmodule : oc_filter

//--- rtl/port_power_overcurrent_ctl.sv
// downstream port power switching and overcurrent sensing, APB slave
// assumes an APB master on CLK_SYS and external open-drain fault outputs on the pins
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// R1 - one shared power/sense pin per port
// R2 - ganged mode uses one pin for all
// R3 - ganged mode set only by configuration
// R4 - ganged overcurrent flags every port
// R5 - individual mode after reset
// R6 - power off drives pin low, pull-up off
// R7 - power on releases pin, pull-up on
// R8 - switch pulls pin low on fault
// R9 - sample pin while port enabled
// R10 - long low pulse flags overcurrent
// R11 - two low groups in window flag
// R12 - short transients are rejected
// R13 - per-port charger supply indication on pins
// R14 - single width 0 to 15 ms, default 5
// R15 - window 1 ms steps, default 20 ms
// R16 - lockout after power on, default 10
// R17 - 1 ms tick from core clock
// R18 - sticky overcurrent flags, cleared by request
module port_power_overcurrent_ctl #(
    parameter int TICK_CYC = pwr_oc_pkg::TICK_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [pwr_oc_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [pwr_oc_pkg::NUM_PORTS-1:0] PORT_POWER_SENSE_PINS_I,
    output logic [pwr_oc_pkg::NUM_PORTS-1:0] PORT_POWER_SENSE_PINS_O,
    output logic [pwr_oc_pkg::NUM_PORTS-1:0] PORT_POWER_SENSE_PINS_OE_N,
    output logic [pwr_oc_pkg::NUM_PORTS-1:0] PORT_POWER_SENSE_PULLUP,
    input wire logic SHARED_POWER_SENSE_PIN_I,
    output logic SHARED_POWER_SENSE_PIN_O,
    output logic SHARED_POWER_SENSE_PIN_OE_N,
    output logic SHARED_POWER_SENSE_PULLUP,
    output logic [pwr_oc_pkg::NUM_PORTS-1:0] OC_FLAG,
    output logic IRQ
);
    import pwr_oc_pkg::*;

    localparam top_state_t RESET_STATE = '{
        min_width: MIN_WIDTH_RST,
        inactive: INACTIVE_RST,
        lockout: LOCKOUT_RST,
        default: '0
    };
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

    top_state_t s;
    top_state_t next_s;
    logic [NUM_FILT-1:0] filt_en;
    logic [NUM_FILT-1:0] oc_vec;
    logic [NUM_PORTS-1:0] oc_set;
    logic [NUM_PORTS-1:0] port_on;
    logic [NUM_PORTS-1:0] clr_mask;
    reg_sel_t sel;
    logic wr;

    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
        reg_sel_t r;
        r = SEL_NONE;
        unique case (a)
            {IDX_MIN_WIDTH, 2'b00}: r = SEL_MIN_WIDTH;
            {IDX_INACTIVE, 2'b00}: r = SEL_INACTIVE;
            {IDX_LOCKOUT, 2'b00}: r = SEL_LOCKOUT;
            {IDX_PWR_CTRL, 2'b00}: r = SEL_PWR_CTRL;
            {IDX_CONFIG, 2'b00}: r = SEL_CONFIG;
            {IDX_STATUS, 2'b00}: r = SEL_STATUS;
            {IDX_MASK, 2'b00}: r = SEL_MASK;
            {IDX_PIN_STATE, 2'b00}: r = SEL_PIN_STATE;
            default: r = SEL_NONE;
        endcase
        return r;
    endfunction : decode

    function automatic logic [31:0] read_mux(input reg_sel_t rs, input top_state_t st);
        logic [31:0] d;
        d = '0;
        unique case (rs)
            SEL_MIN_WIDTH: d[WIDTH_W-1:0] = st.min_width;
            SEL_INACTIVE: d[WIN_W-1:0] = st.inactive;
            SEL_LOCKOUT: d[WIN_W-1:0] = st.lockout;
            SEL_PWR_CTRL: d[NUM_PORTS-1:0] = st.pwr;
            SEL_CONFIG: begin
                d[CFG_GANG_BIT] = st.gang;
                d[CFG_BC_LSB +: NUM_PORTS] = st.bc;
            end
            SEL_STATUS: d[NUM_PORTS-1:0] = st.status;
            SEL_MASK: d[NUM_PORTS-1:0] = st.mask;
            SEL_PIN_STATE: d[NUM_FILT-1:0] = st.sync2;
            default: d = '0;
        endcase
        return d;
    endfunction : read_mux

    oc_filter_if fif[NUM_FILT] ();

    // pin is enabled for sensing only once it is actually released
    assign filt_en = s.gang ? {s.sh_oe_n, {NUM_PORTS{1'b0}}}
                            : {1'b0, s.pin_oe_n}; // see R2, R9

    generate
        for (genvar g = 0; g < NUM_FILT; g++) begin : g_filt
            assign fif[g].en = filt_en[g];
            assign fif[g].low = !s.sync2[g]; // see R8, R9
            assign fif[g].tick = s.tick;
            assign fif[g].width = s.min_width;
            assign fif[g].window = s.inactive;
            assign fif[g].lockout = s.lockout;
            assign oc_vec[g] = fif[g].oc;
            oc_filter u_filt (
                .clk(CLK_SYS),
                .rst_n(RSTN),
                .fif(fif[g])
            );
        end
    endgenerate

    assign sel = decode(PADDR);
    assign wr = PSEL && PENABLE && PWRITE && s.pready;
    // charger supply presence keeps the port pin released
    assign port_on = s.pwr | s.bc; // see R13
    assign oc_set = s.gang ? {NUM_PORTS{oc_vec[SHARED_IDX]}}
                           : oc_vec[NUM_PORTS-1:0]; // see R4
    assign clr_mask = (wr && sel == SEL_STATUS) ? PWDATA[NUM_PORTS-1:0] : '0;

    always_comb begin
        next_s = s;
        next_s.sync1 = {SHARED_POWER_SENSE_PIN_I, PORT_POWER_SENSE_PINS_I};
        next_s.sync2 = s.sync1;
        // 1 ms tick divider
        next_s.tick = 1'b0;
        if (s.tick_cnt == TICK_LAST) begin
            next_s.tick_cnt = '0;
            next_s.tick = 1'b1; // see R17
        end else begin
            next_s.tick_cnt = s.tick_cnt + 16'h0001;
        end
        // individual pins sit in power off while ganged
        next_s.pin_oe_n = s.gang ? '0 : port_on; // see R1, R5, R6, R7
        next_s.sh_oe_n = s.gang && (|port_on); // see R2
        if (wr) begin
            unique case (sel)
                SEL_MIN_WIDTH: next_s.min_width = PWDATA[WIDTH_W-1:0]; // see R14
                SEL_INACTIVE: next_s.inactive = PWDATA[WIN_W-1:0]; // see R15
                SEL_LOCKOUT: next_s.lockout = PWDATA[WIN_W-1:0]; // see R16
                SEL_PWR_CTRL: next_s.pwr = PWDATA[NUM_PORTS-1:0];
                SEL_CONFIG: begin
                    next_s.gang = PWDATA[CFG_GANG_BIT]; // see R3
                    next_s.bc = PWDATA[CFG_BC_LSB +: NUM_PORTS]; // see R13
                end
                SEL_MASK: next_s.mask = PWDATA[NUM_PORTS-1:0];
                default: next_s.mask = s.mask;
            endcase
        end
        // a new event beats a clear in the same cycle
        next_s.status = (s.status & ~clr_mask) | oc_set; // see R18
        next_s.irq = |(next_s.status & next_s.mask);
        next_s.pready = PSEL && !PENABLE;
        if (PSEL && !PENABLE) begin
            next_s.prdata = read_mux(sel, s);
            next_s.pslverr = (sel == SEL_NONE);
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign PRDATA = s.prdata;
    assign PREADY = s.pready;
    assign PSLVERR = s.pslverr;
    assign PORT_POWER_SENSE_PINS_O = '0;
    assign PORT_POWER_SENSE_PINS_OE_N = s.pin_oe_n;
    assign PORT_POWER_SENSE_PULLUP = s.pin_oe_n;
    assign SHARED_POWER_SENSE_PIN_O = 1'b0;
    assign SHARED_POWER_SENSE_PIN_OE_N = s.sh_oe_n;
    assign SHARED_POWER_SENSE_PULLUP = s.sh_oe_n;
    assign OC_FLAG = s.status;
    assign IRQ = s.irq;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);

    a_pin_power_off: assert property (!s.gang && !port_on[0] |=> !PORT_POWER_SENSE_PINS_OE_N[0]
        && !PORT_POWER_SENSE_PULLUP[0]) // see R6
        else $error("powered-off pin not driven low");
    a_pin_power_on: assert property (!s.gang && port_on[0] |=> PORT_POWER_SENSE_PINS_OE_N[0]
        && PORT_POWER_SENSE_PULLUP[0]) // see R7
        else $error("powered-on pin not released");
    a_gang_all_flags: assert property (s.gang && oc_vec[SHARED_IDX] |=> &OC_FLAG) // see R4
        else $error("ganged overcurrent did not flag all ports");
    a_gang_pins_off: assert property (s.gang |=> PORT_POWER_SENSE_PINS_OE_N == '0) // see R2
        else $error("per-port pins released in ganged mode");
    a_sticky_hold: assert property (|(OC_FLAG & ~clr_mask) // see R18
        |=> (OC_FLAG & $past(OC_FLAG & ~clr_mask)) == $past(OC_FLAG & ~clr_mask))
        else $error("overcurrent flag lost without clear");
    a_flag_set: assert property (!s.gang && |oc_vec[NUM_PORTS-1:0] // see R18
        |=> (OC_FLAG & $past(oc_vec[NUM_PORTS-1:0])) == $past(oc_vec[NUM_PORTS-1:0]))
        else $error("overcurrent event not recorded");
    a_irq_level: assert property (IRQ == |(OC_FLAG & s.mask))
        else $error("interrupt does not follow masked status");
    a_tick_spacing: assert property (s.tick |=> !s.tick [*2]) // see R17
        else $error("tick pulses too close");
    a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready after setup cycle");
endmodule : port_power_overcurrent_ctl

//--- verification/pwr_switch_model.sv
// external power switch / poly fuse seen from the port pins, one per pin
// assumes bit 6 is the shared pin and the bench commands faults
`timescale 1ns/1ps
module pwr_switch_model (
    input wire logic clk,
    input wire logic [6:0] oe_n,
    input wire logic [6:0] o,
    input wire logic [6:0] pull_en,
    input wire logic [6:0] fault,
    output logic [6:0] pin
);
    // undriven pin without pull-up wanders, so it never reads as a clean level
    logic flip = 1'b0;
    always_ff @(posedge clk) begin
        flip <= ~flip;
    end
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            if (!oe_n[i]) begin
                pin[i] = o[i];
            end else if (fault[i]) begin
                pin[i] = 1'b0;
            end else if (pull_en[i]) begin
                pin[i] = 1'b1;
            end else begin
                pin[i] = flip ^ i[0];
            end
        end
    end
endmodule : pwr_switch_model

//--- verification/tb_top.sv
// self-checking bench: APB master, pin faults through the switch model
// assumes a 1 ms tick shortened to 20 cycles
`timescale 1ns/1ps
module tb_top;
    import pwr_oc_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, irq, sh_o, sh_oe_n, sh_pu, err;
    logic [5:0] pin_o, pin_oe_n, pin_pu, oc_flag, r1, r2;
    logic [6:0] fault = '0, lvl;
    int seed = 97, num_errors = 0, num_checks = 0, p;

    port_power_overcurrent_ctl #(.TICK_CYC(20)) DUT (
        .CLK_SYS(clk_sys), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PORT_POWER_SENSE_PINS_I(lvl[5:0]),
        .PORT_POWER_SENSE_PINS_O(pin_o), .PORT_POWER_SENSE_PINS_OE_N(pin_oe_n),
        .PORT_POWER_SENSE_PULLUP(pin_pu), .SHARED_POWER_SENSE_PIN_I(lvl[6]),
        .SHARED_POWER_SENSE_PIN_O(sh_o), .SHARED_POWER_SENSE_PIN_OE_N(sh_oe_n),
        .SHARED_POWER_SENSE_PULLUP(sh_pu), .OC_FLAG(oc_flag), .IRQ(irq)
    );
    pwr_switch_model PSW (
        .clk(clk_sys), .oe_n({sh_oe_n, pin_oe_n}), .o({sh_o, pin_o}),
        .pull_en({sh_pu, pin_pu}), .fault(fault), .pin(lvl)
    );

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    // one transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            wrap_up();
        end
    endtask : apb

    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk("read data", exp, rd);
        chk("read error", 32'h0, {31'h0, err});
    endtask : rd_chk

    function automatic logic [6:0] exp_oe(input logic [5:0] pw, input logic [5:0] bc,
                                          input logic gang);
        return gang ? {|(pw | bc), 6'h00} : {1'b0, pw | bc};
    endfunction : exp_oe

    task automatic pin_chk(input logic [6:0] exp);
        cyc(2);
        chk("output enable", {25'h0, exp}, {25'h0, sh_oe_n, pin_oe_n});
        chk("pull-up", {25'h0, exp}, {25'h0, sh_pu, pin_pu});
        chk("drive value", 32'h0, {25'h0, sh_o, pin_o});
    endtask : pin_chk

    task automatic pulse(input int i, input int n);
        fault[i] <= 1'b1;
        cyc(n);
        fault[i] <= 1'b0;
    endtask : pulse

    initial begin
        repeat (100000) @(posedge clk_sys);
        num_errors++;
        wrap_up();
    end

    initial begin
        cyc(6);
        rstn <= 1'b1;
        pin_chk(7'h00);
        rd_chk(IDX_MIN_WIDTH, 32'h5);
        rd_chk(IDX_INACTIVE, 32'h14);
        rd_chk(IDX_LOCKOUT, 32'h0A);
        apb(1'b0, 16'h3000, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        apb(1'b1, IDX_MIN_WIDTH, 32'h2);
        apb(1'b1, IDX_INACTIVE, 32'h3);
        apb(1'b1, IDX_LOCKOUT, 32'h4);
        for (int k = 0; k < 4; k++) begin
            r1 = 6'($random(seed));
            r2 = 6'($random(seed));
            apb(1'b1, IDX_PWR_CTRL, {26'h0, r1});
            apb(1'b1, IDX_CONFIG, {18'h0, r2, 8'h00});
            pin_chk(exp_oe(r1, r2, 1'b0));
            rd_chk(IDX_PIN_STATE, {25'h0, exp_oe(r1, r2, 1'b0)});
            rd_chk(IDX_CONFIG, {18'h0, r2, 8'h00});
        end
        // gang write clears the charger bits, so only the power bits count
        apb(1'b1, IDX_CONFIG, 32'h1);
        pin_chk(exp_oe(r1, 6'h00, 1'b1));
        apb(1'b1, IDX_CONFIG, 32'h0);
        apb(1'b1, IDX_PWR_CTRL, 32'h0);
        pin_chk(7'h00);
        // fault already present at power on must be masked by the lockout
        p = $unsigned($random(seed)) % 6;
        fault[p] <= 1'b1;
        apb(1'b1, IDX_PWR_CTRL, 32'h1 << p);
        cyc(40);
        fault[p] <= 1'b0;
        cyc(100);
        chk("lockout", 32'h0, {26'h0, oc_flag});
        pulse(p, 10);
        cyc(100);
        chk("short pulse", 32'h0, {26'h0, oc_flag});
        pulse(p, 10);
        cyc(20);
        pulse(p, 10);
        cyc(10);
        chk("double pulse", 32'h1 << p, {26'h0, oc_flag});
        chk("masked irq", 32'h0, {31'h0, irq});
        apb(1'b1, IDX_MASK, 32'h1 << p);
        cyc(2);
        chk("irq", 32'h1, {31'h0, irq});
        rd_chk(IDX_STATUS, 32'h1 << p);
        apb(1'b1, IDX_STATUS, 32'h3F);
        cyc(2);
        chk("cleared", 32'h0, {25'h0, irq, oc_flag});
        cyc(80);
        fault[p] <= 1'b1;
        cyc(15);
        chk("long early", 32'h0, {26'h0, oc_flag});
        cyc(55);
        chk("long pulse", 32'h1 << p, {26'h0, oc_flag});
        fault[p] <= 1'b0;
        cyc(30);
        chk("sticky", 32'h1 << p, {26'h0, oc_flag});
        apb(1'b1, IDX_STATUS, 32'h3F);
        apb(1'b1, IDX_CONFIG, 32'h1);
        apb(1'b1, IDX_PWR_CTRL, 32'h3F);
        cyc(130);
        fault[6] <= 1'b1;
        cyc(70);
        chk("gang flags", 32'h3F, {26'h0, oc_flag});
        fault[6] <= 1'b0;
        wrap_up();
    end
endmodule : tb_top
